// ===== hw/gpp_params.svh
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

// I/O addresses of the port, relative to the port's base
`define GPP_ADDR_PIN_INPUT    2'h0
`define GPP_ADDR_DIRECTION    2'h1
`define GPP_ADDR_OUTPUT_DATA  2'h2

// Reset values
`define GPP_RST_DIRECTION     8'h00
`define GPP_RST_OUTPUT_DATA   8'h00

// Pin value settle time after a software write, in system clock periods
`define GPP_READBACK_CYCLES   2

`endif

// ===== hw/gpp_pkg.sv
package gpp_pkg;

    // I/O bus operation codes
    typedef enum logic [1:0] {
        GPP_OP_NONE,
        GPP_OP_WRITE,
        GPP_OP_SET_BIT,
        GPP_OP_CLR_BIT
    } gpp_op_t;

    // One I/O-space request from the core
    typedef struct packed {
        gpp_op_t    op;
        logic [1:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } gpp_req_t;

    // Per-pin pad control
    typedef struct packed {
        logic [7:0] drive_en;
        logic [7:0] drive_val;
        logic [7:0] pullup_en;
    } gpp_pad_t;

endpackage

// ===== hw/gpp_port.sv
`timescale 1ns/10ps
`include "gpp_params.svh"
module gpp_port
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    input  wire logic             CLK_EN,
    input  wire gpp_req_t         IO_REQ,
    input  wire logic             GLOBAL_PULLUP_DISABLE,
    input  wire logic [WIDTH-1:0] ALT_OWN,
    input  wire logic [WIDTH-1:0] ALT_DRIVE_EN,
    input  wire logic [WIDTH-1:0] ALT_DRIVE_VAL,
    input  wire logic [WIDTH-1:0] PAD_IN,
    output logic      [WIDTH-1:0] IO_RDATA,
    output logic      [WIDTH-1:0] PAD_OUT,
    output logic      [WIDTH-1:0] PAD_OE,
    output logic      [WIDTH-1:0] PAD_PULLUP
);

    logic [WIDTH-1:0] direction_register_q;
    logic [WIDTH-1:0] output_data_register_q;
    logic [WIDTH-1:0] pin_input_register_q;
    logic [WIDTH-1:0] sync_latch;
    logic [WIDTH-1:0] pad_oe_d;
    logic [WIDTH-1:0] pad_out_d;
    logic [WIDTH-1:0] pad_pullup_d;
    logic [WIDTH-1:0] pin_sample;

    // Apply a full write or a single-bit set/clear to one register
    function automatic logic [WIDTH-1:0] apply_op(
        input logic [WIDTH-1:0] cur,
        input gpp_req_t         req
    );
        logic [WIDTH-1:0] mask;
        mask = '0;
        mask[req.bit_sel] = 1'b1;
        case (req.op)
            GPP_OP_WRITE:   apply_op = req.wdata[WIDTH-1:0];
            GPP_OP_SET_BIT: apply_op = cur | mask;
            GPP_OP_CLR_BIT: apply_op = cur & ~mask;
            default:        apply_op = cur;
        endcase
    endfunction

    // Direction register; reset clears to all inputs
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            direction_register_q <= `GPP_RST_DIRECTION;
        end else if (CLK_EN && IO_REQ.addr == `GPP_ADDR_DIRECTION) begin
            direction_register_q <= apply_op(direction_register_q, IO_REQ);
        end
    end

    // Output data register; also the pull-up select for inputs
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            output_data_register_q <= `GPP_RST_OUTPUT_DATA;
        end else if (CLK_EN && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA) begin
            output_data_register_q <= apply_op(output_data_register_q, IO_REQ);
        end
    end

    // Pad controls from the register state; pins not owned by an alternate
    // function keep plain I/O behaviour
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (ALT_OWN[i]) begin
                pad_oe_d[i]     = ALT_DRIVE_EN[i];
                pad_out_d[i]    = ALT_DRIVE_VAL[i];
                pad_pullup_d[i] = 1'b0;
            end else begin
                pad_oe_d[i]     = direction_register_q[i];
                pad_out_d[i]    = output_data_register_q[i];
                pad_pullup_d[i] = !direction_register_q[i] && output_data_register_q[i]
                                  && !GLOBAL_PULLUP_DISABLE;
            end
        end
    end

    // Pad outputs registered; the reset term is also combinational so the
    // pads float while reset is held, clock or no clock
    logic [WIDTH-1:0] pad_oe_q;
    logic [WIDTH-1:0] pad_pullup_q;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pad_oe_q     <= '0;
            pad_pullup_q <= '0;
            PAD_OUT      <= '0;
        end else if (CLK_EN) begin
            pad_oe_q     <= pad_oe_d;
            pad_pullup_q <= pad_pullup_d;
            PAD_OUT      <= pad_out_d;
        end
    end
    assign PAD_OE     = RST_N ? pad_oe_q : '0;
    assign PAD_PULLUP = RST_N ? pad_pullup_q : '0;

    // Sampled level: pad when floating, own drive when driving. The drive is
    // taken from the register side, not the registered pad, so a written value
    // reaches the latch in the cycle after the write and is readable one period on
    logic [WIDTH-1:0] drive_now;
    assign drive_now  = RST_N ? pad_oe_d : '0;
    assign pin_sample = (drive_now & pad_out_d) | (~drive_now & PAD_IN);

    // Sync latch, open while the clock is high
    always_latch begin
        if (SYS_CLK) begin
            sync_latch = pin_sample;
        end
    end

    // Latched value into the input register at the next rising edge
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pin_input_register_q <= '0;
        end else if (CLK_EN) begin
            pin_input_register_q <= sync_latch;
        end
    end

    // Read data registered; the pin location ignores writes
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            IO_RDATA <= '0;
        end else if (CLK_EN) begin
            case (IO_REQ.addr)
                `GPP_ADDR_PIN_INPUT:   IO_RDATA <= pin_input_register_q;
                `GPP_ADDR_DIRECTION:   IO_RDATA <= direction_register_q;
                `GPP_ADDR_OUTPUT_DATA: IO_RDATA <= output_data_register_q;
                default:               IO_RDATA <= '0;
            endcase
        end
    end

    // Helpers for checks
    logic             past_valid_q;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    sequence s_write_dir;
        IO_REQ.op == GPP_OP_WRITE && IO_REQ.addr == `GPP_ADDR_DIRECTION && CLK_EN;
    endsequence

    // Full write of the output data, no alternate function in the way
    sequence s_write_data;
        IO_REQ.op == GPP_OP_WRITE && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA && CLK_EN
        && ALT_OWN == '0;
    endsequence

    // One enabled idle cycle, the software's wait before a read-back
    sequence s_idle_enabled;
        IO_REQ.op == GPP_OP_NONE && CLK_EN && ALT_OWN == '0;
    endsequence

    // Disable held two cycles leaves no pull-up on
    chk_pullup_disable: assert property (@(posedge SYS_CLK)
        GLOBAL_PULLUP_DISABLE ##1 GLOBAL_PULLUP_DISABLE |=> PAD_PULLUP == '0)
        else $error("pull-up on while globally disabled");

    // Pads float for as long as reset is held
    chk_reset_tristate: assert property (@(posedge SYS_CLK)
        !RST_N |-> PAD_OE == '0 && PAD_PULLUP == '0)
        else $error("pin driven during reset");

    // Both writable registers come out of reset cleared
    chk_reset_clear: assert property (@(posedge SYS_CLK)
        !RST_N |=> direction_register_q == '0 && output_data_register_q == '0)
        else $error("registers not cleared by reset");

    // A full write replaces the direction byte
    chk_dir_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_write_dir |=> direction_register_q == $past(IO_REQ.wdata))
        else $error("direction write lost");

    // Bit set on the data register touches one pin only
    chk_bit_set_only: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IO_REQ.op == GPP_OP_SET_BIT && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA && CLK_EN
        |=> output_data_register_q == ($past(output_data_register_q)
            | (WIDTH'(1) << $past(IO_REQ.bit_sel))))
        else $error("bit set touched other pins");

    // Bit clear on the direction register touches one pin only
    chk_bit_clr_only: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IO_REQ.op == GPP_OP_CLR_BIT && IO_REQ.addr == `GPP_ADDR_DIRECTION && CLK_EN
        |=> direction_register_q == ($past(direction_register_q)
            & ~(WIDTH'(1) << $past(IO_REQ.bit_sel))))
        else $error("bit clear touched other pins");

    // Registered drive trails the registers by one cycle
    chk_output_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && ALT_OWN == '0 |=> PAD_OUT == $past(output_data_register_q)
            && PAD_OE == $past(direction_register_q))
        else $error("output drive does not follow registers");

    // Pull-up only for inputs with data one and no global disable
    chk_pullup_table: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && ALT_OWN == '0 |=> PAD_PULLUP == ($past(~direction_register_q
            & output_data_register_q) & {WIDTH{!$past(GLOBAL_PULLUP_DISABLE)}}))
        else $error("pull-up does not follow table");

    // Written value on driven pins is in the pin register after one idle cycle
    chk_readback_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        past_valid_q ##0 s_write_data ##1 s_idle_enabled
        |=> (pin_input_register_q & direction_register_q)
            == (output_data_register_q & direction_register_q))
        else $error("written value not readable in time");

    // A full write replaces the output data byte
    chk_data_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IO_REQ.op == GPP_OP_WRITE && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA && CLK_EN
        |=> output_data_register_q == $past(IO_REQ.wdata))
        else $error("output data write lost");

    // Bit set on the direction register touches one pin only
    chk_bit_set_dir: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IO_REQ.op == GPP_OP_SET_BIT && IO_REQ.addr == `GPP_ADDR_DIRECTION && CLK_EN
        |=> direction_register_q == ($past(direction_register_q)
            | (WIDTH'(1) << $past(IO_REQ.bit_sel))))
        else $error("direction bit set touched other pins");

    // Bit clear on the data register touches one pin only
    chk_bit_clr_data: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        IO_REQ.op == GPP_OP_CLR_BIT && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA && CLK_EN
        |=> output_data_register_q == ($past(output_data_register_q)
            & ~(WIDTH'(1) << $past(IO_REQ.bit_sel))))
        else $error("data bit clear touched other pins");

    // Each location answers with its own register one cycle after the address
    chk_rdata_dir: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && IO_REQ.addr == `GPP_ADDR_DIRECTION
        |=> IO_RDATA == $past(direction_register_q))
        else $error("direction read data wrong");

    chk_rdata_data: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && IO_REQ.addr == `GPP_ADDR_OUTPUT_DATA
        |=> IO_RDATA == $past(output_data_register_q))
        else $error("output data read data wrong");

    chk_rdata_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && IO_REQ.addr == `GPP_ADDR_PIN_INPUT
        |=> IO_RDATA == $past(pin_input_register_q))
        else $error("pin read data wrong");

    // The spare location reads as zero
    chk_rdata_unmapped: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && IO_REQ.addr == 2'h3 |=> IO_RDATA == '0)
        else $error("unmapped read not zero");

    // Writes aimed at the pin location change no register
    chk_pin_readonly: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN && IO_REQ.addr == `GPP_ADDR_PIN_INPUT
        |=> $stable(direction_register_q) && $stable(output_data_register_q))
        else $error("pin location write changed a register");

    // Pin register loads what the latch held over the low phase
    chk_sync_capture: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN |=> pin_input_register_q == $past(sync_latch))
        else $error("pin register missed the latch value");

    // Clock enable low freezes both writable registers, the pin register and the read data
    chk_freeze_state: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !CLK_EN |=> $stable(direction_register_q) && $stable(output_data_register_q)
            && $stable(pin_input_register_q) && $stable(IO_RDATA))
        else $error("state moved while clock enable low");

    // A driven pin never has its pull-up on as well
    chk_drive_no_pullup: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (PAD_OE & PAD_PULLUP) == '0)
        else $error("pull-up on a driven pin");

    // Alternate pins follow their owner, the rest keep their direction bit
    chk_alt_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN |=> (PAD_OE & $past(ALT_OWN)) == $past(ALT_DRIVE_EN & ALT_OWN))
        else $error("alternate drive enable lost");

    chk_alt_others: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN |=> (PAD_OE & ~$past(ALT_OWN))
            == $past(direction_register_q & ~ALT_OWN))
        else $error("plain pins disturbed by alternate function");

endmodule

// ===== dv/gpp_pad_model.sv
`timescale 1ns/10ps
// Board side of the pins: external drivers, else pull-up, else floating
module gpp_pad_model
    import gpp_pkg::*;
(
    input  wire logic       clk,
    input  wire gpp_pad_t   pads,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_level
);
    logic [7:0] float_q = 8'h5a;
    // Undriven pins wander each cycle so a stale level never reads as valid
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Port driver wins over the board, the board over the weak pull-up
    always_comb begin
        pin_level = (pads.drive_en & pads.drive_val)
                  | (~pads.drive_en & ext_en & ext_val)
                  | (~pads.drive_en & ~ext_en & pads.pullup_en)
                  | (~pads.drive_en & ~ext_en & ~pads.pullup_en & float_q);
    end
endmodule

// ===== dv/gpp_port_tb.sv
`timescale 1ns/10ps
module gpp_port_tb;
    import gpp_pkg::*;
    logic       SYS_CLK = 1'b0;
    logic       RST_N = 1'b0;
    logic       CLK_EN = 1'b1;
    gpp_req_t   IO_REQ = '0;
    logic       GLOBAL_PULLUP_DISABLE = 1'b0;
    logic [7:0] ALT_OWN = 8'h00, ALT_DRIVE_EN = 8'h00, ALT_DRIVE_VAL = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] PAD_IN, IO_RDATA, PAD_OUT, PAD_OE, PAD_PULLUP, v;
    gpp_pad_t   pads;
    int         n_errors = 0;
    int         samples_checked = 0;
    // 40 MHz system clock
    always #12.5 SYS_CLK = ~SYS_CLK;
    assign pads = '{drive_en: PAD_OE, drive_val: PAD_OUT, pullup_en: PAD_PULLUP};
    gpp_port #(.WIDTH(8)) gpp_port_i (.SYS_CLK, .RST_N, .CLK_EN, .IO_REQ,
        .GLOBAL_PULLUP_DISABLE, .ALT_OWN, .ALT_DRIVE_EN, .ALT_DRIVE_VAL, .PAD_IN,
        .IO_RDATA, .PAD_OUT, .PAD_OE, .PAD_PULLUP);
    gpp_pad_model gpp_pad_model_i (.clk(SYS_CLK), .pads(pads), .ext_en(ext_en),
        .ext_val(ext_val), .pin_level(PAD_IN));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, then the address is held with no operation
    task automatic req(input gpp_op_t op, input logic [1:0] a, input logic [2:0] s,
                       input logic [7:0] wd);
        @(posedge SYS_CLK);
        IO_REQ <= '{op, a, s, wd};
        @(posedge SYS_CLK);
        IO_REQ <= '{GPP_OP_NONE, a, 3'h0, 8'h00};
    endtask
    // Two extra edges cover the synchronizer delay on the pin location
    task automatic rd(input logic [1:0] a);
        req(GPP_OP_NONE, a, 3'h0, 8'h00);
        repeat (2) @(posedge SYS_CLK);
        #1 v = IO_RDATA;
    endtask
    // Pad outputs are registered, so give them time to land
    task automatic pads_are(input logic [7:0] oe, input logic [7:0] dv, input logic [7:0] pu);
        repeat (3) @(posedge SYS_CLK);
        #1 check("pad_oe", oe, PAD_OE);
        check("pad_out", dv & oe, PAD_OUT & PAD_OE);
        check("pad_pullup", pu, PAD_PULLUP);
    endtask
    task automatic test_reset;
        rd(2'h1);
        check("direction", 8'h00, v);
        rd(2'h2);
        check("output_data", 8'h00, v);
        pads_are(8'h00, 8'h00, 8'h00);
        $display("test_reset done");
    endtask
    // Every direction/data pair per nibble; output low reached before high
    task automatic test_truth;
        for (int p = 0; p < 2; p++) begin
            @(posedge SYS_CLK);
            GLOBAL_PULLUP_DISABLE <= p[0];
            req(GPP_OP_WRITE, 2'h1, 3'h0, 8'hcc);
            req(GPP_OP_WRITE, 2'h2, 3'h0, 8'haa);
            pads_are(8'hcc, 8'haa, p ? 8'h00 : 8'h22);
        end
        GLOBAL_PULLUP_DISABLE <= 1'b0;
        $display("test_truth done");
    endtask
    task automatic test_bits;
        req(GPP_OP_WRITE, 2'h1, 3'h0, 8'h00);
        req(GPP_OP_WRITE, 2'h2, 3'h0, 8'ha5);
        req(GPP_OP_SET_BIT, 2'h2, 3'h1, 8'h00);
        req(GPP_OP_CLR_BIT, 2'h2, 3'h7, 8'h00);
        req(GPP_OP_SET_BIT, 2'h1, 3'h0, 8'h00);
        rd(2'h2);
        check("output_data", 8'h27, v);
        rd(2'h1);
        check("direction", 8'h01, v);
        pads_are(8'h01, 8'h01, 8'h26);
        $display("test_bits done");
    endtask
    task automatic test_pin;
        @(posedge SYS_CLK);
        ext_en <= 8'hfe;
        ext_val <= 8'h50;
        rd(2'h0);
        check("pin_input", 8'h51, v);
        req(GPP_OP_WRITE, 2'h0, 3'h0, 8'hff);
        rd(2'h0);
        check("pin_input", 8'h51, v);
        rd(2'h3);
        check("unmapped", 8'h00, v);
        req(GPP_OP_CLR_BIT, 2'h2, 3'h0, 8'h00);
        rd(2'h0);
        check("pin_input", 8'h50, v);
        $display("test_pin done");
    endtask
    // A write while the clock enable is low must be lost
    task automatic test_freeze;
        @(posedge SYS_CLK);
        CLK_EN <= 1'b0;
        req(GPP_OP_WRITE, 2'h1, 3'h0, 8'hff);
        @(posedge SYS_CLK);
        CLK_EN <= 1'b1;
        rd(2'h1);
        check("direction", 8'h01, v);
        $display("test_freeze done");
    endtask
    task automatic test_alt_reset;
        @(posedge SYS_CLK);
        ALT_OWN <= 8'h80;
        ALT_DRIVE_EN <= 8'h80;
        ALT_DRIVE_VAL <= 8'h80;
        pads_are(8'h81, 8'h80, 8'h26);
        // Reset lands mid-cycle: pads must float without waiting for an edge
        @(negedge SYS_CLK);
        RST_N = 1'b0;
        #1 check("pad_oe", 8'h00, PAD_OE);
        check("pad_pullup", 8'h00, PAD_PULLUP);
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        rd(2'h2);
        check("output_data", 8'h00, v);
        $display("test_alt_reset done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence after 8 cycles of reset
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        test_reset();
        test_truth();
        test_bits();
        test_pin();
        test_freeze();
        test_alt_reset();
        report_and_stop();
    end
    // Tests need under a hundred cycles; this is far beyond that
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule
